// file: hdl/swr_page.sv
/*
 * Register page of the eight channel switch: pin state, output and
 * activity latches, search mask, polarity and control, plus the
 * reset-or-strobe pin and the identity store.
 * Assumes a serial command engine that decodes function commands,
 * drives page reads and writes, and signals command events.
 */
`include "swr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module swr_page #(
  parameter int NCH = 8,
  parameter logic [7:0] FAMILY = 8'h5A, // arbitrary value
  parameter logic [47:0] SERIAL = 48'h0000_0000_0001 // arbitrary value
) (
  // clock and power-on reset
  input wire logic clk_sys,
  input wire logic nrst,
  // command engine
  input wire logic rom_done,
  input wire swr_pkg::swr_req_t req,
  input wire swr_pkg::swr_evt_t evt,
  output logic [7:0] rdata,
  output logic ctrl_open,
  output logic overdrive,
  // identity
  input wire logic id_bit_next,
  input wire logic id_restart,
  output logic id_bit,
  output logic [63:0] id_code,
  output logic id_valid,
  // channel pins, open drain
  input wire logic [NCH-1:0] channel_io_in,
  output logic [NCH-1:0] channel_io_oe,
  // reset-or-strobe pin, open drain
  input wire logic reset_or_strobe_pin_in,
  input wire logic strobe_req,
  output logic reset_or_strobe_pin_oe,
  // supply status and search result
  input wire logic vcc_powered,
  output logic search_hit
);

  logic [7:0] pin_q, pin_d;
  logic [NCH-1:0] out_q, out_d;
  logic [NCH-1:0] act_q, act_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] pol_q, pol_d;
  logic [3:0] ctrl_q, ctrl_d;
  logic open_q, open_d;
  swr_pkg::swr_speed_t spd_q, spd_d;
  logic [NCH-1:0] pin_prev_q;
  logic [7:0] rdata_q, rdata_d;
  logic pulse_q, pulse_d;
  logic prime_q;
  logic [NCH-1:0] act_set;
  logic pin_reset;
  logic [NCH-1:0] chan_src, chan_match;
  logic [7:0] ctrl_rd;

  // ==========================================================
  // identity store
  swr_idrom #(
    .FAMILY(FAMILY),
    .SERIAL(SERIAL)
  ) u_id (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .bit_next(id_bit_next),
    .bit_restart(id_restart),
    .id_bit(id_bit),
    .id_code(id_code),
    .id_valid(id_valid)
  );

  // ==========================================================
  // reset-or-strobe pin
  assign pin_reset = !ctrl_q[`SWR_CTRL_PIN_MODE] && !reset_or_strobe_pin_in;
  assign reset_or_strobe_pin_oe = pulse_q;

  always_comb begin
    pulse_d = 1'b0;
    // only channel commands strobe; page reads never do
    if (ctrl_q[`SWR_CTRL_PIN_MODE] && strobe_req) begin
      pulse_d = 1'b1;
    end
  end

  // ==========================================================
  // command sequencing and speed
  always_comb begin
    open_d = open_q;
    spd_d = spd_q;
    if (rom_done) begin
      open_d = 1'b1;
    end
    if (evt.overdrive_cmd && spd_q == swr_pkg::SWR_SPEED_STD) begin
      spd_d = swr_pkg::SWR_SPEED_OD;
    end
  end

  // ==========================================================
  // channel latches
  // no previous pin sample in the first cycle after reset
  assign act_set = prime_q ? (channel_io_in ^ pin_prev_q) : '0;

  always_comb begin
    out_d = out_q;
    act_d = act_q;
    pin_d = pin_q;
    if (evt.sample_pins) begin
      pin_d = 8'(channel_io_in);
    end
    if (evt.chan_write) begin
      out_d = evt.chan_data[NCH-1:0];
    end
    if (pin_reset) begin
      out_d = '1;
    end
    if (pin_reset || (evt.reset_activity && open_q)) begin
      act_d = '0;
    end
    // a change in the clearing cycle still sets its bit
    act_d = act_d | act_set;
  end

  // ==========================================================
  // search registers, writable only via the search write command
  always_comb begin
    mask_d = mask_q;
    pol_d = pol_q;
    ctrl_d = ctrl_q;
    if (req.wr && open_q) begin
      unique case (req.addr)
        `SWR_ADDR_MASK: mask_d = req.wdata;
        `SWR_ADDR_POLARITY: pol_d = req.wdata;
        `SWR_ADDR_CTRL: begin
          ctrl_d[2:0] = req.wdata[2:0];
          // power-on latch can only be cleared by software
          ctrl_d[3] = ctrl_q[3] & req.wdata[3];
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // read mux
  assign ctrl_rd = {vcc_powered, 3'h0, ctrl_q};

  always_comb begin
    rdata_d = `SWR_UNDEF_DATA;
    unique case (req.addr)
      `SWR_ADDR_PIN_STATE: rdata_d = pin_q;
      `SWR_ADDR_OUT_LATCH: rdata_d = 8'(out_q);
      `SWR_ADDR_ACT_LATCH: rdata_d = 8'(act_q);
      `SWR_ADDR_MASK: rdata_d = mask_q;
      `SWR_ADDR_POLARITY: rdata_d = pol_q;
      `SWR_ADDR_CTRL: rdata_d = ctrl_rd;
      `SWR_ADDR_FF_LO, `SWR_ADDR_PAGE_END: rdata_d = `SWR_READ_FF;
      default: rdata_d = `SWR_UNDEF_DATA;
    endcase
    if (!req.rd) begin
      rdata_d = rdata_q;
    end
  end

  // ==========================================================
  // conditional search qualification
  assign chan_src = ctrl_q[`SWR_CTRL_PLS] ? act_q : channel_io_in;
  assign chan_match = ~(chan_src ^ pol_q[NCH-1:0]);

  always_comb begin
    if (ctrl_q[`SWR_CTRL_PORL]) begin
      search_hit = 1'b1;
    end else if (ctrl_q[`SWR_CTRL_CT]) begin
      search_hit = &(chan_match | ~mask_q[NCH-1:0]);
    end else begin
      search_hit = |(chan_match & mask_q[NCH-1:0]);
    end
  end

  // ==========================================================
  // registers; all volatile, cleared by power-on except the power-on latch, which is set, act_q also by the reset pin
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      act_q <= '0;
      mask_q <= `SWR_RST_MASK;
      pol_q <= `SWR_RST_POL;
      ctrl_q <= 4'(`SWR_RST_CTRL);
      open_q <= 1'b0;
      spd_q <= swr_pkg::SWR_SPEED_STD;
      pin_q <= 8'h00;
      pin_prev_q <= '0;
      prime_q <= 1'b0;
      rdata_q <= 8'h00;
      pulse_q <= 1'b0;
    end else begin
      act_q <= act_d;
      mask_q <= mask_d;
      pol_q <= pol_d;
      ctrl_q <= ctrl_d;
      open_q <= open_d;
      spd_q <= spd_d;
      pin_q <= pin_d;
      pin_prev_q <= channel_io_in;
      prime_q <= 1'b1;
      rdata_q <= rdata_d;
      pulse_q <= pulse_d;
    end
  end

  // output latch is not power-on cleared and ignores ESD reinit
  always_ff @(posedge clk_sys) begin
    out_q <= out_d;
  end

  assign channel_io_oe = ~out_q;
  assign rdata = rdata_q;
  assign ctrl_open = open_q;
  assign overdrive = (spd_q == swr_pkg::SWR_SPEED_OD);

  // ==========================================================
  // checks
  sequence s_mask_write;
    req.wr && open_q && req.addr == `SWR_ADDR_MASK;
  endsequence

  property p_mask_write;
    @(posedge clk_sys) disable iff (!nrst)
    s_mask_write |=> mask_q == $past(req.wdata);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  property p_mask_hold;
    @(posedge clk_sys) disable iff (!nrst)
    !(req.wr && req.addr == `SWR_ADDR_MASK) |=> $stable(mask_q);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed");

  property p_ff_read;
    @(posedge clk_sys) disable iff (!nrst)
    req.rd && req.addr == `SWR_ADDR_PAGE_END |=> rdata == 8'hFF;
  endproperty
  a_ff_read: assert property (p_ff_read) else $error("tail not FF");

  property p_pin_reset;
    @(posedge clk_sys) disable iff (!nrst)
    pin_reset |=> (&out_q) && act_q == $past(act_set);
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset lost");

  property p_no_strobe_on_read;
    @(posedge clk_sys) disable iff (!nrst)
    req.rd && !strobe_req |=> !reset_or_strobe_pin_oe;
  endproperty
  a_no_strobe_on_read: assert property (p_no_strobe_on_read) else $error("read strobed");

  property p_overdrive;
    @(posedge clk_sys) disable iff (!nrst)
    evt.overdrive_cmd && !overdrive |=> overdrive;
  endproperty
  a_overdrive: assert property (p_overdrive) else $error("no overdrive");

  property p_ro_write;
    @(posedge clk_sys) disable iff (!nrst)
    req.wr && req.addr == `SWR_ADDR_PIN_STATE && !evt.sample_pins
      |=> $stable(pin_q);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("ro reg written");

  property p_sample;
    @(posedge clk_sys) disable iff (!nrst)
    evt.sample_pins |=> pin_q == 8'($past(channel_io_in));
  endproperty
  a_sample: assert property (p_sample) else $error("pin sample wrong");

  property p_pin_read;
    @(posedge clk_sys) disable iff (!nrst)
    req.rd && req.addr == `SWR_ADDR_PIN_STATE |=> rdata == $past(pin_q);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin read wrong");

endmodule
`default_nettype wire

// file: hdl/swr_defines.svh
/*
 * Constants of the switch register page: register addresses, field
 * positions, reset values and the identity layout.
 * Assumes nothing of its surroundings.
 */
`ifndef SWR_DEFINES_SVH
`define SWR_DEFINES_SVH

// ==========================================================
// register page addresses
`define SWR_ADDR_PIN_STATE 16'h0088
`define SWR_ADDR_OUT_LATCH 16'h0089
`define SWR_ADDR_ACT_LATCH 16'h008A
`define SWR_ADDR_MASK 16'h008B
`define SWR_ADDR_POLARITY 16'h008C
`define SWR_ADDR_CTRL 16'h008D
`define SWR_ADDR_FF_LO 16'h008E
`define SWR_ADDR_PAGE_END 16'h008F

// ==========================================================
// control/status fields
`define SWR_CTRL_PLS 0
`define SWR_CTRL_CT 1
`define SWR_CTRL_PIN_MODE 2
`define SWR_CTRL_PORL 3
`define SWR_CTRL_VCCP 7
`define SWR_CTRL_WR_MASK 8'h0F

// ==========================================================
// reset values and fixed data
`define SWR_RST_ACT 8'h00
`define SWR_RST_MASK 8'h00
`define SWR_RST_POL 8'h00
`define SWR_RST_CTRL 8'h08
`define SWR_READ_FF 8'hFF
`define SWR_UNDEF_DATA 8'h00
`define SWR_CRC_INIT 8'h00

// ==========================================================
// identity layout
`define SWR_ID_BITS 64
`define SWR_ID_DATA_BITS 56
`define SWR_SERIAL_BITS 48

`endif

// file: hdl/swr_pkg.sv
/*
 * Types shared by the switch register page files.
 * Assumes swr_defines.svh for the numbers.
 */
package swr_pkg;

  // page access from the serial command engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } swr_req_t;

  // command events from the serial command engine
  typedef struct packed {
    logic chan_write;
    logic [7:0] chan_data;
    logic reset_activity;
    logic sample_pins;
    logic overdrive_cmd;
    logic esd_reinit;
  } swr_evt_t;

  typedef enum logic [1:0] {
    SWR_SPEED_STD,
    SWR_SPEED_OD,
    SWR_SPEED_HOLD
  } swr_speed_t;

endpackage

// file: hdl/swr_crc8.sv
/*
 * Bit-serial identity check value generator, poly x^8+x^5+x^4+1.
 * Assumes data bits are offered least significant bit first.
 */
`include "swr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module swr_crc8 (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic clear,
  input wire logic shift_en,
  input wire logic din,
  // result
  output logic [7:0] crc,
  output logic zero
);

  logic [7:0] crc_q;
  logic [7:0] crc_d;
  logic fb;

  // ==========================================================
  // shift register with xor feedback
  always_comb begin
    fb = crc_q[0] ^ din;
    crc_d = crc_q;
    if (clear) begin
      crc_d = `SWR_CRC_INIT;
    end else if (shift_en) begin
      crc_d = {fb, crc_q[7:1]} ^ {4'h0, fb, fb, 2'h0};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      crc_q <= `SWR_CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;
  assign zero = (crc_q == 8'h00);

  property p_clear_zero;
    @(posedge clk_sys) disable iff (!nrst)
    clear |=> zero;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("crc not cleared");

endmodule
`default_nettype wire

// file: hdl/swr_idrom.sv
/*
 * Identity store: family, serial and its check byte, shifted out
 * least significant bit first, with a self check at reset release.
 * Assumes swr_crc8 and the shared constants.
 */
`include "swr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module swr_idrom #(
  parameter logic [7:0] FAMILY = 8'h5A, // arbitrary value
  parameter logic [47:0] SERIAL = 48'h0000_0000_0001 // arbitrary value
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // serial read of the identity
  input wire logic bit_next,
  input wire logic bit_restart,
  output logic id_bit,
  // full identity and check
  output logic [63:0] id_code,
  output logic id_valid
);

  typedef enum {ST_GEN, ST_CHK, ST_DONE} swr_id_st_t;
  swr_id_st_t st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic [7:0] chk_q, chk_d;
  logic [5:0] pos_q, pos_d;
  logic valid_q, valid_d;
  logic [55:0] data56;
  logic crc_din, crc_clr, crc_sh, crc_zero;
  logic [7:0] crc_val;

  assign data56 = {SERIAL, FAMILY};

  swr_crc8 u_crc (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clear(crc_clr),
    .shift_en(crc_sh),
    .din(crc_din),
    .crc(crc_val),
    .zero(crc_zero)
  );

  // ==========================================================
  // generate the check byte, then verify by shifting it back in
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    chk_d = chk_q;
    valid_d = valid_q;
    crc_clr = 1'b0;
    crc_sh = 1'b0;
    crc_din = 1'b0;
    unique case (st_q)
      ST_GEN: begin
        crc_sh = 1'b1;
        crc_din = data56[cnt_q];
        cnt_d = cnt_q + 6'h01;
        if (cnt_q == 6'(`SWR_ID_DATA_BITS - 1)) begin
          st_d = ST_CHK;
          cnt_d = 6'h00;
        end
      end
      ST_CHK: begin
        if (cnt_q == 6'h00) begin
          chk_d = crc_val;
        end
        crc_sh = 1'b1;
        crc_din = (cnt_q == 6'h00) ? crc_val[0] : chk_q[cnt_q[2:0]];
        cnt_d = cnt_q + 6'h01;
        if (cnt_q == 6'h07) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        valid_d = crc_zero;
        st_d = ST_DONE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_GEN;
      cnt_q <= 6'h00;
      chk_q <= 8'h00;
      valid_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      chk_q <= chk_d;
      valid_q <= valid_d;
    end
  end

  // ==========================================================
  // serial output pointer
  always_comb begin
    pos_d = pos_q;
    if (bit_restart) begin
      pos_d = 6'h00;
    end else if (bit_next) begin
      pos_d = pos_q + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pos_q <= 6'h00;
    end else begin
      pos_q <= pos_d;
    end
  end

  assign id_code = {chk_q, data56};
  assign id_bit = id_code[pos_q];
  assign id_valid = valid_q;

  property p_valid_after_check;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(st_q == ST_DONE) |=> (valid_q == crc_zero);
  endproperty
  a_valid_after_check: assert property (p_valid_after_check) else $error("identity check wrong");

endmodule
`default_nettype wire

// file: sim/swr_master_model.sv
/*
 * Command engine model: page reads and writes, command events and
 * serial identity reads toward the switch register page.
 * Assumes the page samples every request at the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module swr_master_model (
  // clock
  input wire logic clk_sys,
  // page access and events
  output logic rom_done,
  output var swr_pkg::swr_req_t req,
  output var swr_pkg::swr_evt_t evt,
  input wire logic [7:0] rdata,
  // identity
  output logic id_bit_next,
  output logic id_restart,
  input wire logic id_bit
);
  // ==========================================================
  // idle levels
  initial begin
    rom_done = 1'b0;
    req = '0;
    evt = '0;
    id_bit_next = 1'b0;
    id_restart = 1'b0;
  end

  // ==========================================================
  // page access, one byte per request
  task automatic page_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk_sys);
    req.rd = 1'b0;
    req.addr = ~a; // released address does not linger
    d = rdata;
  endtask

  task automatic page_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk_sys);
    req.wr = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask

  task automatic pulse_evt(input swr_pkg::swr_evt_t e);
    @(negedge clk_sys);
    evt = e;
    @(negedge clk_sys);
    evt = '0;
  endtask

  // function command completes before any control access
  task automatic open_ctrl();
    @(negedge clk_sys);
    rom_done = 1'b1;
    @(negedge clk_sys);
    rom_done = 1'b0;
  endtask

  // identity bits arrive lsb first
  task automatic read_id(output logic [63:0] v);
    @(negedge clk_sys);
    id_restart = 1'b1;
    @(negedge clk_sys);
    id_restart = 1'b0;
    for (int k = 0; k < 64; k++) begin
      v[k] = id_bit;
      id_bit_next = 1'b1;
      @(negedge clk_sys);
      id_bit_next = 1'b0;
      @(negedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// file: sim/swr_page_bench.sv
/*
 * Self-checking bench of the switch register page, random data from
 * a fixed seed. Assumes the command engine model beside it.
 */
`timescale 1ns/1ps
`default_nettype none

module swr_page_bench;
  localparam logic [7:0] FAM = 8'hA7; // arbitrary value
  localparam logic [47:0] SER = 48'h3C5A_9E12_0B77; // arbitrary value
  logic clk_sys, nrst, vcc_powered, strobe_req, rsp_ext, mon_en;
  logic rom_done, id_bit_next, id_restart, id_bit, id_valid;
  logic ctrl_open, overdrive, search_hit, rsp_oe;
  logic [7:0] rdata, ext_pins, pins_oe, d, w, a, lat;
  logic [7:0] ex [8];
  logic [63:0] id_code, id_rd, id_exp;
  logic [31:0] rs;
  swr_pkg::swr_req_t req;
  swr_pkg::swr_evt_t evt, e;
  int n_fail, samples_checked, i;

  // ==========================================================
  // clock, design and command engine
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  swr_page #(.FAMILY(FAM), .SERIAL(SER)) swr_page_i (
    .clk_sys(clk_sys), .nrst(nrst), .rom_done(rom_done), .req(req),
    .evt(evt), .rdata(rdata), .ctrl_open(ctrl_open),
    .overdrive(overdrive), .id_bit_next(id_bit_next),
    .id_restart(id_restart), .id_bit(id_bit), .id_code(id_code),
    .id_valid(id_valid), .channel_io_in(ext_pins & ~pins_oe),
    .channel_io_oe(pins_oe),
    .reset_or_strobe_pin_in(rsp_ext & ~rsp_oe),
    .strobe_req(strobe_req), .reset_or_strobe_pin_oe(rsp_oe),
    .vcc_powered(vcc_powered), .search_hit(search_hit)
  );

  swr_master_model master_i (
    .clk_sys(clk_sys), .rom_done(rom_done), .req(req), .evt(evt),
    .rdata(rdata), .id_bit_next(id_bit_next), .id_restart(id_restart),
    .id_bit(id_bit)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  function automatic logic [7:0] crc8(input logic [63:0] v, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 0; k < n; k++) begin
      if (c[0] ^ v[k]) c = (c >> 1) ^ 8'h8C;
      else c = c >> 1;
    end
    return c;
  endfunction

  function automatic logic exp_hit(input logic [7:0] src, input logic [7:0] m,
                                   input logic [7:0] p, input logic [7:0] c);
    logic [7:0] mt;
    mt = ~(src ^ p);
    if (c[3]) return 1'b1;
    if (c[1]) return &(mt | ~m);
    return |(mt & m);
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic close_out();
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // page reads must never strobe the pin
  always @(negedge clk_sys) begin
    if (mon_en) chk_bit(rsp_oe, 1'b0);
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    close_out();
  end

  // ==========================================================
  // scenarios
  initial begin
    n_fail = 0;
    samples_checked = 0;
    rs = 32'd77248;
    nrst = 1'b0;
    vcc_powered = 1'b0;
    strobe_req = 1'b0;
    mon_en = 1'b0;
    rsp_ext = 1'b0;
    rs = xs(rs);
    ext_pins = rs[7:0];
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rsp_ext = 1'b1;
    repeat (70) @(negedge clk_sys);
    chk_bit(overdrive, 1'b0);
    chk_bit(ctrl_open, 1'b0);
    master_i.page_rd(16'h0089, d);
    chk_byte(d, 8'hFF);
    master_i.page_rd(16'h008A, d);
    chk_byte(d, 8'h00);
    master_i.page_rd(16'h008B, d);
    chk_byte(d, 8'h00);
    master_i.page_rd(16'h008D, d);
    chk_byte(d, 8'h08);
    // identity, serially and in parallel
    id_exp = {8'h00, SER, FAM};
    id_exp[63:56] = crc8(id_exp, 56);
    master_i.read_id(id_rd);
    for (i = 0; i < 8; i++) begin
      chk_byte(id_rd[8*i +: 8], id_exp[8*i +: 8]);
      chk_byte(id_code[8*i +: 8], id_exp[8*i +: 8]);
    end
    chk_byte(crc8(id_rd, 64), 8'h00);
    chk_bit(id_valid, 1'b1);
    // writes refused before control access opens
    master_i.page_wr(16'h008B, 8'h5A);
    master_i.page_rd(16'h008B, d);
    chk_byte(d, 8'h00);
    master_i.open_ctrl();
    chk_bit(ctrl_open, 1'b1);
    ex[1] = 8'hFF;
    ex[2] = 8'h00;
    ex[6] = 8'hFF;
    ex[7] = 8'hFF;
    for (i = 0; i < 8; i++) begin
      rs = xs(rs);
      w = (i == 5) ? (rs[7:0] & 8'hF3) : rs[7:0];
      master_i.page_wr(16'h0088 + 16'(i), w);
      if (i == 3 || i == 4) ex[i] = w;
      if (i == 5) ex[i] = {4'h0, w[3], w[2:0]};
    end
    for (i = 1; i < 8; i++) begin
      master_i.page_rd(16'h0088 + 16'(i), d);
      chk_byte(d, ex[i]);
    end
    // search answer from pins or the cleared activity latch
    lat = ex[5][0] ? 8'h00 : ext_pins;
    chk_bit(search_hit, exp_hit(lat, ex[3], ex[4], ex[5]));
    rs = xs(rs);
    master_i.page_wr({8'h00, rs[7:0] & 8'h7F}, rs[15:8]);
    master_i.page_rd({8'h00, rs[7:0] & 8'h7F}, d);
    chk_byte(d, 8'h00);
    // activity follows pin changes and clears on command
    a = ext_pins;
    rs = xs(rs);
    ext_pins = rs[7:0];
    repeat (3) @(negedge clk_sys);
    master_i.page_rd(16'h008A, d);
    chk_byte(d, a ^ ext_pins);
    e = '0;
    e.reset_activity = 1'b1;
    master_i.pulse_evt(e);
    master_i.page_rd(16'h008A, d);
    chk_byte(d, 8'h00);
    // channel write survives reinit, pins sampled on event
    rs = xs(rs);
    lat = rs[7:0];
    e = '0;
    e.chan_write = 1'b1;
    e.chan_data = lat;
    master_i.pulse_evt(e);
    e = '0;
    e.esd_reinit = 1'b1;
    master_i.pulse_evt(e);
    master_i.page_rd(16'h0089, d);
    chk_byte(d, lat);
    chk_byte(pins_oe, ~lat);
    e = '0;
    e.sample_pins = 1'b1;
    master_i.pulse_evt(e);
    master_i.page_rd(16'h0088, d);
    chk_byte(d, ext_pins & lat);
    e = '0;
    e.overdrive_cmd = 1'b1;
    master_i.pulse_evt(e);
    chk_bit(overdrive, 1'b1);
    // strobe mode: reads silent, low pin leaves latch alone
    master_i.page_wr(16'h008D, 8'h04);
    master_i.page_rd(16'h008D, d);
    chk_byte(d, 8'h04);
    mon_en = 1'b1;
    for (i = 0; i < 3; i++) master_i.page_rd(16'h0088 + 16'(i), d);
    mon_en = 1'b0;
    strobe_req = 1'b1;
    @(negedge clk_sys);
    strobe_req = 1'b0;
    chk_bit(rsp_oe, 1'b1);
    @(negedge clk_sys);
    chk_bit(rsp_oe, 1'b0);
    rsp_ext = 1'b0;
    repeat (3) @(negedge clk_sys);
    rsp_ext = 1'b1;
    master_i.page_rd(16'h0089, d);
    chk_byte(d, lat);
    master_i.page_wr(16'h008D, 8'h00);
    // second power-on reset clears volatile state
    @(negedge clk_sys);
    vcc_powered = 1'b1;
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    chk_bit(overdrive, 1'b0);
    master_i.page_rd(16'h008B, d);
    chk_byte(d, 8'h00);
    master_i.page_rd(16'h008D, d);
    chk_byte(d, 8'h88);
    master_i.page_rd(16'h008A, d);
    chk_byte(d, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
